// ==== design/psc_cfg.svh ====
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
`define PSC_CLK_MHZ 100
`define PSC_OFS_CTRL 32'h0000_0000
`define PSC_OFS_LEN 32'h0000_0004
`define PSC_OFS_PRE 32'h0000_0008
`define PSC_OFS_STAT 32'h0000_000C
`define PSC_OFS_BITS 32'h0000_0010
`define PSC_OFS_BYTE 32'h0000_0014
`define PSC_CTRL_W 5
`define PSC_CTRL_FORCE 5
`define PSC_CTRL_RST 5'h00
`define PSC_LEN_RST 32'h0000_0400
`define PSC_PRE_RST 8'hFF
`define PSC_STATUS_MIN_US 10
`define PSC_STATUS_MIN_CYC (`PSC_STATUS_MIN_US * `PSC_CLK_MHZ)
`define PSC_ERR_TO_US 500
`define PSC_ERR_TO_CYC (`PSC_ERR_TO_US * `PSC_CLK_MHZ)
`define PSC_INIT_US 55
`define PSC_INIT_CYC (`PSC_INIT_US * `PSC_CLK_MHZ)
`define PSC_SERIAL_CFG_CLOCK_PER_NS 8
`define PSC_CD2CU_NS (4 * `PSC_SERIAL_CFG_CLOCK_PER_NS)
`define PSC_CD2CU_CYC ((`PSC_CD2CU_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_UCLK_INIT_CNT 8532
`define PSC_POR_MS 100
`define PSC_POR_CYC (`PSC_POR_MS * 1000 * `PSC_CLK_MHZ)
`define PSC_NSYNC 7
`define PSC_S_REQ 0
`define PSC_S_STAT 1
`define PSC_S_DONE 2
`define PSC_S_CEN 3
`define PSC_S_SCLK 4
`define PSC_S_SDAT 5
`define PSC_S_UCLK 6
`endif

// ==== design/psc_pkg.sv ====
package psc_pkg;
    typedef enum logic [3:0] {
        PSC_POR, PSC_RESET, PSC_RELEASE, PSC_CONFIG, PSC_WAIT_DONE,
        PSC_EDGES, PSC_INIT, PSC_USER, PSC_ERROR
    } psc_state_t;
    typedef struct packed {
        logic dual_val;
        logic dual_drive;
        logic pre_chk;
        logic uclk_en;
        logic auto_rst;
    } psc_ctrl_t;
    typedef struct packed {
        logic        act;
        logic        wr;
        logic [7:0]  addr;
    } psc_aph_t;
endpackage : psc_pkg

// ==== design/psc_chain.sv ====
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "psc_cfg.svh"
module psc_chain
    import psc_pkg::*;
#(
    parameter logic [31:0] POR_CYC    = `PSC_POR_CYC,
    parameter logic [31:0] ERR_TO_CYC = `PSC_ERR_TO_CYC,
    parameter logic [31:0] INIT_CYC   = `PSC_INIT_CYC,
    parameter logic [31:0] UCLK_CNT   = `PSC_UCLK_INIT_CNT
) (
    // Clock, reset and freeze.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Configuration request and shared open-drain lines.
    input  wire logic        config_req_n,
    input  wire logic        status_in,
    output logic             status_out,
    output logic             status_oe,
    input  wire logic        done_in,
    output logic             done_out,
    output logic             done_oe,
    // Chain enables.
    input  wire logic        chain_enable_in_n,
    output logic             chain_enable_out_n,
    // Serial link and user init clock.
    input  wire logic        serial_cfg_clock,
    input  wire logic        serial_cfg_data,
    output logic             serial_cfg_data_out,
    output logic             serial_cfg_data_oe,
    input  wire logic        user_init_clock
);
    localparam logic [31:0] STATUS_MIN = `PSC_STATUS_MIN_CYC;
    localparam logic [31:0] CU_CYC     = `PSC_CD2CU_CYC;

    logic [`PSC_NSYNC-1:0] pin_raw;
    logic [`PSC_NSYNC-1:0] s1_r;
    logic [`PSC_NSYNC-1:0] s2_r;
    logic                  sclk_q_r;
    logic                  uclk_q_r;

    assign pin_raw = {user_init_clock, serial_cfg_data, serial_cfg_clock,
                      chain_enable_in_n, done_in, status_in, config_req_n};

    // Every pin in pin_raw passes two flip-flops before any logic reads it; the AHB-Lite inputs are read directly.
    for (genvar i = 0; i < `PSC_NSYNC; i++) begin : g_sync
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                s1_r[i] <= 1'b0;
                s2_r[i] <= 1'b0;
            end else if (ce) begin
                s1_r[i] <= pin_raw[i];
                s2_r[i] <= s1_r[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_q_r <= 1'b0;
            uclk_q_r <= 1'b0;
        end else if (ce) begin
            sclk_q_r <= s2_r[`PSC_S_SCLK];
            uclk_q_r <= s2_r[`PSC_S_UCLK];
        end
    end

    logic req_low;
    logic stat_hi;
    logic done_hi;
    logic chain_on;
    logic sdat;
    logic sclk_rise;
    logic sclk_fall;
    logic uclk_rise;

    assign req_low   = !s2_r[`PSC_S_REQ];
    assign stat_hi   = s2_r[`PSC_S_STAT];
    assign done_hi   = s2_r[`PSC_S_DONE];
    assign chain_on  = !s2_r[`PSC_S_CEN];
    assign sdat      = s2_r[`PSC_S_SDAT];
    assign sclk_rise = s2_r[`PSC_S_SCLK] && !sclk_q_r;
    assign sclk_fall = !s2_r[`PSC_S_SCLK] && sclk_q_r;
    assign uclk_rise = s2_r[`PSC_S_UCLK] && !uclk_q_r;

    // Register file group.
    psc_aph_t    aph_r;
    psc_aph_t    aph_nxt;
    psc_ctrl_t   ctrl_r;
    psc_ctrl_t   ctrl_nxt;
    logic [31:0] len_r;
    logic [31:0] len_nxt;
    logic [7:0]  pre_r;
    logic [7:0]  pre_nxt;
    logic        force_r;
    logic        force_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic        force_take;

    // Loader group.
    psc_state_t  state_r;
    psc_state_t  state_nxt;
    logic [31:0] timer_r;
    logic [31:0] timer_nxt;
    logic [31:0] bits_r;
    logic [31:0] bits_nxt;
    logic [7:0]  shift_r;
    logic [7:0]  shift_nxt;
    logic [7:0]  byte_r;
    logic [7:0]  byte_nxt;
    logic [1:0]  falls_r;
    logic [1:0]  falls_nxt;
    logic        ceo_n_r;
    logic        ceo_n_nxt;
    logic [7:0]  new_byte;

    always_comb begin
        aph_nxt    = aph_r;
        ctrl_nxt   = ctrl_r;
        len_nxt    = len_r;
        pre_nxt    = pre_r;
        force_nxt  = force_r;
        hrdata_nxt = hrdata_r;
        if (force_take) begin
            force_nxt = 1'b0;
        end
        if (aph_r.act && aph_r.wr) begin
            unique case ({24'h00_0000, aph_r.addr})
                `PSC_OFS_CTRL: begin
                    ctrl_nxt = psc_ctrl_t'(hwdata[`PSC_CTRL_W-1:0]);
                    // The set wins over a consumption in the same cycle.
                    if (hwdata[`PSC_CTRL_FORCE]) begin
                        force_nxt = 1'b1;
                    end
                end
                `PSC_OFS_LEN: len_nxt = hwdata;
                `PSC_OFS_PRE: pre_nxt = hwdata[7:0];
                default: ;
            endcase
        end
        aph_nxt.act  = hsel && hready && htrans[1];
        aph_nxt.wr   = hwrite;
        aph_nxt.addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case ({haddr[31:2], 2'b00})
                `PSC_OFS_CTRL: hrdata_nxt = {27'h000_0000, ctrl_r};
                `PSC_OFS_LEN:  hrdata_nxt = len_r;
                `PSC_OFS_PRE:  hrdata_nxt = {24'h00_0000, pre_r};
                `PSC_OFS_STAT: hrdata_nxt = {22'h00_0000, sdat, chain_on, done_hi,
                                             stat_hi, !ceo_n_r, 1'b0, state_r};
                `PSC_OFS_BITS: hrdata_nxt = bits_r;
                `PSC_OFS_BYTE: hrdata_nxt = {24'h00_0000, byte_r};
                default:       hrdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_r    <= '0;
            ctrl_r   <= `PSC_CTRL_RST;
            len_r    <= `PSC_LEN_RST;
            pre_r    <= `PSC_PRE_RST;
            force_r  <= 1'b0;
            hrdata_r <= 32'h0000_0000;
        end else if (ce) begin
            aph_r    <= aph_nxt;
            ctrl_r   <= ctrl_nxt;
            len_r    <= len_nxt;
            pre_r    <= pre_nxt;
            force_r  <= force_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    assign new_byte = {sdat, shift_r[7:1]};

    always_comb begin
        state_nxt  = state_r;
        timer_nxt  = timer_r + 32'h0000_0001;
        bits_nxt   = bits_r;
        shift_nxt  = shift_r;
        byte_nxt   = byte_r;
        falls_nxt  = falls_r;
        ceo_n_nxt  = ceo_n_r;
        force_take = 1'b0;
        unique case (state_r)
            PSC_POR: begin
                if (timer_r >= POR_CYC - 32'h0000_0001) begin
                    state_nxt = PSC_RESET;
                    timer_nxt = '0;
                end
            end
            PSC_RESET: begin
                bits_nxt  = '0;
                ceo_n_nxt = 1'b1;
                if (!req_low && timer_r >= STATUS_MIN - 32'h0000_0001) begin
                    state_nxt = PSC_RELEASE;
                end
            end
            PSC_RELEASE: begin
                if (stat_hi) begin
                    state_nxt = PSC_CONFIG;
                end
            end
            PSC_CONFIG: begin
                if (!stat_hi) begin
                    state_nxt = PSC_RESET;
                    timer_nxt = '0;
                end else if (force_r) begin
                    force_take = 1'b1;
                    state_nxt  = PSC_ERROR;
                    timer_nxt  = '0;
                end else if (chain_on && sclk_rise) begin
                    shift_nxt = new_byte;
                    bits_nxt  = bits_r + 32'h0000_0001;
                    if (bits_r[2:0] == 3'h7) begin
                        byte_nxt = new_byte;
                    end
                    if (ctrl_r.pre_chk && bits_r == 32'h0000_0007 && new_byte != pre_r) begin
                        state_nxt = PSC_ERROR;
                        timer_nxt = '0;
                    end else if (bits_r + 32'h0000_0001 >= len_r) begin
                        state_nxt = PSC_WAIT_DONE;
                        ceo_n_nxt = 1'b0;
                    end
                end
            end
            PSC_WAIT_DONE: begin
                falls_nxt = 2'h0;
                if (!stat_hi) begin
                    state_nxt = PSC_RESET;
                    timer_nxt = '0;
                end else if (done_hi) begin
                    state_nxt = PSC_EDGES;
                end
            end
            PSC_EDGES: begin
                timer_nxt = '0;
                if (sclk_fall) begin
                    falls_nxt = falls_r + 2'h1;
                    if (falls_r == 2'h1) begin
                        state_nxt = PSC_INIT;
                    end
                end
            end
            PSC_INIT: begin
                if (!ctrl_r.uclk_en) begin
                    if (timer_r >= INIT_CYC - 32'h0000_0001) begin
                        state_nxt = PSC_USER;
                    end
                end else if (timer_r < CU_CYC) begin
                    bits_nxt = '0;
                end else begin
                    timer_nxt = timer_r;
                    if (uclk_rise) begin
                        bits_nxt = bits_r + 32'h0000_0001;
                        if (bits_r >= UCLK_CNT - 32'h0000_0001) begin
                            state_nxt = PSC_USER;
                        end
                    end
                end
            end
            PSC_USER: begin
                timer_nxt = timer_r;
            end
            PSC_ERROR: begin
                if (ctrl_r.auto_rst && timer_r >= ERR_TO_CYC - 32'h0000_0001) begin
                    state_nxt = PSC_RELEASE;
                    bits_nxt  = '0;
                    ceo_n_nxt = 1'b1;
                end
            end
        endcase
        if (state_r != PSC_POR && state_r != PSC_RESET && req_low) begin
            state_nxt = PSC_RESET;
            timer_nxt = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= PSC_POR;
            timer_r <= '0;
            bits_r  <= '0;
            shift_r <= 8'h00;
            byte_r  <= 8'h00;
            falls_r <= 2'h0;
            ceo_n_r <= 1'b1;
        end else if (ce) begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            bits_r  <= bits_nxt;
            shift_r <= shift_nxt;
            byte_r  <= byte_nxt;
            falls_r <= falls_nxt;
            ceo_n_r <= ceo_n_nxt;
        end
    end

    // Open-drain lines only ever pull low.
    assign status_out = 1'b0;
    assign done_out   = 1'b0;
    assign status_oe  = state_r == PSC_POR || state_r == PSC_RESET
                     || state_r == PSC_ERROR;
    assign done_oe    = state_r == PSC_POR || state_r == PSC_RESET
                     || state_r == PSC_RELEASE || state_r == PSC_CONFIG
                     || state_r == PSC_ERROR;
    assign chain_enable_out_n = ceo_n_r;

    // In user mode the data pin follows the dual-purpose setting.
    assign serial_cfg_data_oe  = state_r == PSC_USER && ctrl_r.dual_drive;
    assign serial_cfg_data_out = state_r == PSC_USER && ctrl_r.dual_val;

endmodule : psc_chain
`default_nettype wire

// ==== verif/psc_chain_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module psc_chain_chk #(
    parameter logic [31:0] INIT_CYC = 32'h0000_157C
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Configuration pins.
    input wire logic config_req_n,
    input wire logic status_oe,
    input wire logic done_in,
    input wire logic done_oe,
    input wire logic chain_enable_out_n,
    input wire logic serial_cfg_data_oe
);
    logic [15:0] low_cnt_r, low_cnt_nxt, rel_cnt_r, rel_cnt_nxt, init_cnt_r, init_cnt_nxt;
    logic        err_r, err_nxt;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Counters saturate, and a status pulse raised while the request is high is marked as an error pulse.
    always_comb begin
        low_cnt_nxt  = status_oe ? low_cnt_r + {15'h0000, ~&low_cnt_r} : 16'h0000;
        rel_cnt_nxt  = (status_oe && config_req_n) ? rel_cnt_r + {15'h0000, ~&rel_cnt_r} : 16'h0000;
        init_cnt_nxt = (done_in && !status_oe) ? init_cnt_r + {15'h0000, ~&init_cnt_r} : 16'h0000;
        err_nxt      = status_oe && ((low_cnt_r == 16'h0000) ? config_req_n : err_r);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt_r  <= 16'h0000;
            rel_cnt_r  <= 16'h0000;
            init_cnt_r <= 16'h0000;
            err_r      <= 1'b0;
        end else begin
            low_cnt_r  <= low_cnt_nxt;
            rel_cnt_r  <= rel_cnt_nxt;
            init_cnt_r <= init_cnt_nxt;
            err_r      <= err_nxt;
        end
    end
    a_done_on_req: assert property ($fell(config_req_n) |-> ##[1:80] done_oe)
        else $error("completion line not pulled low after request");
    a_status_on_req: assert property ($fell(config_req_n) |-> ##[1:80] status_oe)
        else $error("status line not pulled low after request");
    a_user_exit: assert property ($fell(config_req_n) |-> ##[1:80] !serial_cfg_data_oe)
        else $error("data pin still driven after request");
    a_status_pulse_min: assert property ($fell(status_oe) && !err_r |-> low_cnt_r >= 16'h03E8)
        else $error("status low pulse too short");
    a_status_rel_bound: assert property (rel_cnt_r < 16'hC350)
        else $error("status line held too long after request rose");
    a_chain_with_done: assert property ($fell(done_oe) |-> $fell(chain_enable_out_n))
        else $error("chain enable output not lowered with completion");
    a_done_held: assert property (status_oe |-> done_oe)
        else $error("completion line released during reset");
    a_user_needs_done: assert property ($rose(serial_cfg_data_oe) |-> done_in && !status_oe)
        else $error("user mode entered without completion high");
    a_init_delay: assert property ($rose(serial_cfg_data_oe) |-> {16'h0000, init_cnt_r} >= INIT_CYC)
        else $error("user mode entered too early");
endmodule : psc_chain_chk
bind psc_chain psc_chain_chk #(.INIT_CYC(INIT_CYC)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .config_req_n(config_req_n), .status_oe(status_oe), .done_in(done_in),
    .done_oe(done_oe), .chain_enable_out_n(chain_enable_out_n), .serial_cfg_data_oe(serial_cfg_data_oe)
);
`default_nettype wire

// ==== verif/psc_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module psc_host #(
    parameter int CF2CK_NS = 500000
) (
    // Host drive of the configuration link.
    output logic      config_req_n,
    output logic      serial_cfg_clock,
    output logic      serial_cfg_data,
    // Resolved shared lines.
    input  wire logic status_w,
    input  wire logic done_w
);
    initial begin
        config_req_n     = 1'b1;
        serial_cfg_clock = 1'b0;
        serial_cfg_data  = 1'b0;
    end
    task automatic req_low();
        #3 config_req_n = 1'b0;
        #2000;
    endtask : req_low
    task automatic req_high();
        #3 config_req_n = 1'b1;
        #CF2CK_NS;
    endtask : req_high
    task automatic start();
        wait (status_w);
        #2003;
    endtask : start
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            if (status_w) begin
                serial_cfg_data = b[i];
                #40 serial_cfg_clock = 1'b1;
                #40 serial_cfg_clock = 1'b0;
            end
        end
        // A released data line must not keep showing the last bit.
        serial_cfg_data = ~b[7];
    endtask : send
    task automatic finish();
        wait (done_w);
        #3;
        repeat (2) begin
            #40 serial_cfg_clock = 1'b1;
            #40 serial_cfg_clock = 1'b0;
        end
    endtask : finish
endmodule : psc_host
`default_nettype wire

// ==== verif/psc_chain_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "psc_cfg.svh"
module psc_chain_tb_top;
    logic        hclk, uclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_take = 1'b0, cen_n = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic        ce = 1'b1;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rnd, seed;
    logic        hreadyout, hresp, status_oe, done_oe, cen_out_n, sclk, sdat_host, req_n, sdat_out, sdat_oe;
    int          mismatches = 0, compares = 0;
    logic [31:0] exp_q[$], msk_q[$], adr_q[$];
    wire logic   status_w = !status_oe;
    wire logic   done_w = !done_oe;
    wire logic   sdat_w = sdat_oe ? sdat_out : sdat_host;
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        uclk = 1'b0;
        forever #80 uclk = ~uclk;
    end
    psc_chain #(.POR_CYC(32'h0000_0014), .ERR_TO_CYC(32'h0000_0032), .INIT_CYC(32'h0000_001E),
                .UCLK_CNT(32'h0000_0008)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .config_req_n(req_n), .status_in(status_w), .status_out(),
        .status_oe(status_oe), .done_in(done_w), .done_out(), .done_oe(done_oe), .chain_enable_in_n(cen_n),
        .chain_enable_out_n(cen_out_n), .serial_cfg_clock(sclk), .serial_cfg_data(sdat_w),
        .serial_cfg_data_out(sdat_out), .serial_cfg_data_oe(sdat_oe), .user_init_clock(uclk)
    );
    psc_host #(.CF2CK_NS(12000)) i_host (
        .config_req_n(req_n), .serial_cfg_clock(sclk), .serial_cfg_data(sdat_host),
        .status_w(status_w), .done_w(done_w)
    );
    // Reads note the expected value; the monitor below compares it when the data phase ends.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel    <= 1'b0;
        htrans  <= 2'b00;
        hwdata  <= d;
        rd_take <= !wr;
        if (!wr) begin
            exp_q.push_back(d);
            msk_q.push_back(m);
            adr_q.push_back(a);
        end
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_take <= 1'b0;
    endtask : bus
    always @(posedge hclk) begin
        if (rd_take) begin
            compares++;
            if ((hrdata & msk_q[0]) !== exp_q[0]) begin
                mismatches++;
                $display("[FAIL] reg %h expected %h seen %h", adr_q[0], exp_q[0], hrdata & msk_q[0]);
            end
            exp_q.delete(0);
            msk_q.delete(0);
            adr_q.delete(0);
        end
    end
    task automatic load();
        i_host.start();
        i_host.send(rnd[7:0]);
        i_host.send(rnd[15:8]);
        i_host.finish();
        for (int i = 0; i < 4000 && sdat_oe !== 1'b1; i++) @(posedge hclk);
    endtask : load
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #400000;
        mismatches++;
        final_report();
    end
    initial begin
        seed = 32'h0c4c_e244;
        rnd  = $random(seed);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `PSC_OFS_CTRL, 32'h0000_0000, 32'h0000_003F);
        bus(1'b0, `PSC_OFS_LEN, 32'h0000_0400, 32'hFFFF_FFFF);
        bus(1'b0, `PSC_OFS_PRE, 32'h0000_00FF, 32'h0000_00FF);
        bus(1'b1, 32'h0000_0018, 32'hFFFF_FFFF, 32'h0000_0000);
        bus(1'b0, 32'h0000_0018, 32'h0000_0000, 32'hFFFF_FFFF);
        bus(1'b1, `PSC_OFS_LEN, 32'h0000_0010, 32'h0000_0000);
        bus(1'b1, `PSC_OFS_PRE, {24'h00_0000, rnd[7:0]}, 32'h0000_0000);
        bus(1'b1, `PSC_OFS_CTRL, 32'h0000_001C, 32'h0000_0000);
        i_host.req_low();
        bus(1'b0, `PSC_OFS_STAT, 32'h0000_0001, 32'h0000_00CF);
        i_host.req_high();
        load();
        bus(1'b0, `PSC_OFS_STAT, 32'h0000_03E7, 32'h0000_03EF);
        bus(1'b0, `PSC_OFS_BYTE, {24'h00_0000, rnd[15:8]}, 32'h0000_00FF);
        i_host.req_low();
        bus(1'b0, `PSC_OFS_STAT, 32'h0000_0001, 32'h0000_00CF);
        bus(1'b1, `PSC_OFS_CTRL, 32'h0000_001F, 32'h0000_0000);
        i_host.req_high();
        i_host.start();
        i_host.send(~rnd[7:0]);
        repeat (10) @(posedge hclk);
        bus(1'b0, `PSC_OFS_STAT, 32'h0000_0008, 32'h0000_004F);
        load();
        bus(1'b0, `PSC_OFS_STAT, 32'h0000_03E7, 32'h0000_03EF);
        i_host.req_low();
        i_host.req_high();
        bus(1'b1, `PSC_OFS_CTRL, 32'h0000_002C, 32'h0000_0000);
        repeat (100) @(posedge hclk);
        bus(1'b0, `PSC_OFS_STAT, 32'h0000_0008, 32'h0000_004F);
        i_host.req_low();
        i_host.req_high();
        i_host.start();
        @(posedge hclk);
        cen_n <= 1'b1;
        i_host.send(rnd[7:0]);
        bus(1'b0, `PSC_OFS_BITS, 32'h0000_0000, 32'hFFFF_FFFF);
        cen_n <= 1'b0;
        load();
        bus(1'b0, `PSC_OFS_STAT, 32'h0000_01E7, 32'h0000_03EF);
        bus(1'b0, `PSC_OFS_BYTE, {24'h00_0000, rnd[15:8]}, 32'h0000_00FF);
        final_report();
    end
endmodule : psc_chain_tb_top
`default_nettype wire
